/* shared/tape_exc_pkg.sv */
/*
  shared constants for the tape formatter error, attention and exception ends.
  assumes a single pclk domain and a 32-bit apb register port on the controller end.
*/
package tape_exc_pkg;
  // -----------------------------------------------------------------
  // function codes carried with a launch
  // -----------------------------------------------------------------
  localparam int FUNC_W = 5;
  localparam logic [4:0] FN_NOP = 5'h00;
  localparam logic [4:0] FN_REWIND = 5'h03;
  localparam logic [4:0] FN_ERASE = 5'h0A;
  localparam logic [4:0] FN_WR_MARK = 5'h0B;
  localparam logic [4:0] FN_SPACE_FWD = 5'h0C;
  localparam logic [4:0] FN_SPACE_REV = 5'h0D;
  localparam logic [4:0] FN_WRITE = 5'h18;
  localparam logic [4:0] FN_READ = 5'h1C;
  localparam logic [4:0] FN_LAST_LEGAL = 5'h1F;
  // -----------------------------------------------------------------
  // error register bit positions
  // -----------------------------------------------------------------
  localparam int ERR_W = 16;
  localparam int ERR_BAD_FUNC = 0;
  localparam int ERR_DATA_PAR = 5;
  localparam int ERR_FRAME_PAR = 6;
  localparam int ERR_FMT_CHK = 7;
  localparam int ERR_TIMING = 12;
  localparam int ERR_OP_INCOMPLETE = 13;
  localparam int ERR_NOT_SAFE = 14;
  localparam int ERR_FIX_CHK = 15;
  localparam logic [15:0] CLASS_B_MASK = 16'h7001;
  localparam logic [15:0] DATA_ERR_MASK = 16'h80E0;
  // tape control bit that lets data errors abort a transfer
  localparam int ABORT_ENABLE_BIT = 12;
  // -----------------------------------------------------------------
  // controller apb map
  // -----------------------------------------------------------------
  localparam logic [7:0] A_CMD = 8'h00;
  localparam logic [7:0] A_STATUS = 8'h04;
  localparam logic [7:0] A_ERROR = 8'h08;
  localparam logic [7:0] A_SHARED_SERVICE_REQUEST = 8'h0C;
  localparam logic [7:0] A_TCTRL = 8'h10;
  localparam logic [7:0] A_EVENT = 8'h14;
  // status word bit positions (controller side)
  localparam int ST_FAULT = 0;
  localparam int ST_SSC = 1;
  localparam int ST_ENGAGED = 2;
  localparam int ST_SERVICE = 3;
  localparam int ST_XFER_FAULT = 4;
  localparam int ST_ABORT = 5;
  localparam int ST_WSTOP = 6;
  localparam int ST_BUSY = 7;
  localparam int ST_SHARED_SERVICE_REQUEST_SHIFT = 8;
  // operation timing
  localparam int OP_CYCLES = 16;
  localparam int GAP_CYCLES = 8;
  localparam int UNIT_W = 3;
endpackage

/* shared/tape_link_if.sv */
/*
  link between the formatter exception end and the controller end.
  assumes both ends share pclk; the bench ties instances together.
*/
`timescale 1ns/1ns
interface tape_link_if;
  logic launch;
  logic [4:0] func;
  logic [15:0] tctrl;
  logic err_inject;
  logic [15:0] err_bits;
  logic ssc_in;
  logic limit_in;
  logic err_clear;
  logic shared_service_request_rd;
  logic shared_service_request_wr;
  logic [7:0] shared_service_request_wdata;
  logic [7:0] shared_service_request_rdata;
  logic [15:0] err_q_out;
  logic fault_summary;
  logic ssc_out;
  logic drive_engaged;
  logic shared_service_request;
  logic transfer_fault_line;
  logic end_of_block_abort;
  logic write_stop;
  logic busy;
  modport formatter (
    input launch, func, tctrl, err_inject, err_bits, ssc_in, limit_in, err_clear,
    input shared_service_request_rd, shared_service_request_wr, shared_service_request_wdata,
    output shared_service_request_rdata, err_q_out, fault_summary, ssc_out, drive_engaged,
    output shared_service_request, transfer_fault_line, end_of_block_abort,
    output write_stop, busy
  );
  modport controller (
    output launch, func, tctrl, err_inject, err_bits, ssc_in, limit_in, err_clear,
    output shared_service_request_rd, shared_service_request_wr, shared_service_request_wdata,
    input shared_service_request_rdata, err_q_out, fault_summary, ssc_out, drive_engaged,
    input shared_service_request, transfer_fault_line, end_of_block_abort,
    input write_stop, busy
  );
endinterface

/* src/tape_bus_controller.sv */
/*
  controller end: apb registers that drive the formatter link and report it.
  assumes one formatter on the link; apb slave inserts two wait states on every access.
*/
`timescale 1ns/1ns
module tape_bus_controller (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  tape_link_if.controller link
);
  import tape_exc_pkg::*;

  logic [31:0] prdata_q, prdata_d;
  logic [15:0] tctrl_q, tctrl_d;
  logic launch_q, launch_d, rd_q, rd_d, wr_q, wr_d, inj_q, inj_d, clr_q, clr_d;
  logic ssc_q, ssc_d, lim_q, lim_d, pslverr_q, pslverr_d;
  logic pready_q, pready_d, wait_q, wait_d;
  logic [4:0] func_q, func_d;
  logic [15:0] bits_q, bits_d;
  logic [7:0] awd_q, awd_d;
  logic acc, done;
  logic [31:0] status;

  // -----------------------------------------------------------------
  // apb decode
  // -----------------------------------------------------------------
  always_comb begin
    acc = psel && penable;
    done = acc && pready_q;
    status = 32'h0;
    status[ST_FAULT] = link.fault_summary;
    status[ST_SSC] = link.ssc_out;
    status[ST_ENGAGED] = link.drive_engaged;
    status[ST_SERVICE] = link.shared_service_request;
    status[ST_XFER_FAULT] = link.transfer_fault_line;
    status[ST_ABORT] = link.end_of_block_abort;
    status[ST_WSTOP] = link.write_stop;
    status[ST_BUSY] = link.busy;
    status[ST_SHARED_SERVICE_REQUEST_SHIFT +: 8] = link.shared_service_request_rdata;
    prdata_d = prdata_q;
    tctrl_d = tctrl_q;
    func_d = func_q;
    launch_d = 1'b0;
    rd_d = 1'b0;
    wr_d = 1'b0;
    inj_d = 1'b0;
    clr_d = 1'b0;
    ssc_d = 1'b0;
    lim_d = 1'b0;
    pready_d = 1'b0;
    pslverr_d = 1'b0;
    wait_d = 1'b0;
    bits_d = bits_q;
    awd_d = awd_q;
    // the setup phase asks for the summary so it has settled before read data is taken
    if (psel && !penable && !pwrite && ((paddr == A_SHARED_SERVICE_REQUEST) || (paddr == A_STATUS))) begin
      rd_d = 1'b1;
    end
    // two wait states: one for the summary strobe, one for the read data flop
    if (acc && !pready_q) begin
      if (!wait_q) begin
        wait_d = 1'b1;
      end else begin
        pready_d = 1'b1;
        if (pwrite) begin
          pslverr_d = !((paddr == A_CMD) || (paddr == A_SHARED_SERVICE_REQUEST) || (paddr == A_TCTRL) ||
            (paddr == A_EVENT));
        end else if (paddr == A_CMD) begin
          prdata_d = {26'h0, func_q, 1'b0};
        end else if (paddr == A_STATUS) begin
          prdata_d = status;
        end else if (paddr == A_ERROR) begin
          prdata_d = {16'h0, link.err_q_out};
        end else if (paddr == A_SHARED_SERVICE_REQUEST) begin
          prdata_d = {24'h0, link.shared_service_request_rdata};
        end else if (paddr == A_TCTRL) begin
          prdata_d = {16'h0, tctrl_q};
        end else begin
          prdata_d = 32'h0;
          pslverr_d = 1'b1;
        end
      end
    end
    // a write takes effect only at the edge that completes the transfer
    if (done && pwrite) begin
      if (paddr == A_CMD) begin
        func_d = pwdata[5:1];
        launch_d = pwdata[0];
      end else if (paddr == A_SHARED_SERVICE_REQUEST) begin
        awd_d = pwdata[7:0];
        wr_d = 1'b1;
      end else if (paddr == A_TCTRL) begin
        tctrl_d = pwdata[15:0];
      end else if (paddr == A_EVENT) begin
        bits_d = pwdata[15:0];
        inj_d = 1'b1;
        ssc_d = pwdata[16];
        lim_d = pwdata[17];
        clr_d = pwdata[18];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0;
      tctrl_q <= 16'h0000;
      func_q <= FN_NOP;
      launch_q <= 1'b0;
      rd_q <= 1'b0;
      wr_q <= 1'b0;
      inj_q <= 1'b0;
      clr_q <= 1'b0;
      ssc_q <= 1'b0;
      lim_q <= 1'b0;
      pslverr_q <= 1'b0;
      pready_q <= 1'b0;
      wait_q <= 1'b0;
      bits_q <= 16'h0000;
      awd_q <= 8'h00;
    end else begin
      prdata_q <= prdata_d;
      tctrl_q <= tctrl_d;
      func_q <= func_d;
      launch_q <= launch_d;
      rd_q <= rd_d;
      wr_q <= wr_d;
      inj_q <= inj_d;
      clr_q <= clr_d;
      ssc_q <= ssc_d;
      lim_q <= lim_d;
      pslverr_q <= pslverr_d;
      pready_q <= pready_d;
      wait_q <= wait_d;
      bits_q <= bits_d;
      awd_q <= awd_d;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign link.launch = launch_q;
  assign link.func = func_q;
  assign link.tctrl = tctrl_q;
  assign link.err_inject = inj_q;
  assign link.err_bits = bits_q;
  assign link.ssc_in = ssc_q;
  assign link.limit_in = lim_q;
  assign link.err_clear = clr_q;
  assign link.shared_service_request_rd = rd_q;
  assign link.shared_service_request_wr = wr_q;
  assign link.shared_service_request_wdata = awd_q;
endmodule

/* src/tape_formatter_exc.sv */
/*
  formatter end: error check at launch, attention flag, exception and abort.
  assumes the controller end drives the link on the same pclk, one-cycle strobes.
*/
// The APB slave port and the register addresses were left to the implementer.
// Overview of operation
// - launch runs error check before starting
// - pending error inhibits requested function
// - any set error bit forms summary
// - load during error blocks drive engaged
// - refused launch clears go, raises attention
// - erase, space, tape mark end raise attention
// - rewind raises attention at its start
// - error or slave change raises attention; the code raises it only at the end of an operation that saw it
// - tape limit during operation raises attention
// - controller reads attention summary on request
// - controller services and clears attention flags
// - controller reads status, then error if fault
// - controller polls slaves on slave change
// - transfer error asserts fault line immediately
// - read error aborts block, read finishes
// - write error aborts, stops after gap
// - abort on transfer with pending error
// - abort on class b or bad function
// - data errors abort only when enabled; the code also aborts a transfer on any error in its first cycle
// - attention read puts flag on unit line
// - attention write one clears flag
`timescale 1ns/1ns
module tape_formatter_exc #(
  parameter logic [2:0] UNIT = 3'h0
) (
  input wire logic pclk,
  input wire logic presetn,
  tape_link_if.formatter link
);
  import tape_exc_pkg::*;

  typedef enum logic [3:0] {
    S_IDLE = 4'b0001,
    S_RUN = 4'b0010,
    S_GAP = 4'b0100,
    S_DONE = 4'b1000
  } op_state_t;

  // -----------------------------------------------------------------
  // state
  // -----------------------------------------------------------------
  op_state_t state_q, state_d;
  logic [15:0] err_q, err_d;
  logic [4:0] func_q, func_d;
  logic [7:0] cnt_q, cnt_d;
  logic shared_service_request_flag_q, shared_service_request_flag_d;
  logic ssc_q, ssc_d;
  logic seen_q, seen_d;
  logic engaged_q, engaged_d;
  logic xfault_q, xfault_d;
  logic abort_q, abort_d;
  logic wstop_q, wstop_d;
  logic [7:0] rdata_q, rdata_d;
  logic any_error_summary;
  logic is_xfer, is_write, shared_service_request_set, stale_error_block, new_err, abort_cause;
  logic [15:0] err_next;

  // -----------------------------------------------------------------
  // next state
  // -----------------------------------------------------------------
  always_comb begin
    err_next = err_q | (link.err_inject ? link.err_bits : 16'h0000);
    any_error_summary = |err_q;
    stale_error_block = link.launch && any_error_summary;
    is_xfer = (func_q == FN_READ) || (func_q == FN_WRITE);
    is_write = func_q == FN_WRITE;
    new_err = link.err_inject && (link.err_bits != 16'h0000);
    // class b and bad function always abort, data errors only when enabled
    abort_cause = new_err && (((link.err_bits & CLASS_B_MASK) != 16'h0000) ||
      (link.tctrl[ABORT_ENABLE_BIT] && ((link.err_bits & DATA_ERR_MASK) != 16'h0000)));
    state_d = state_q;
    err_d = link.err_clear ? 16'h0000 : err_next;
    func_d = func_q;
    cnt_d = cnt_q;
    ssc_d = ssc_q | link.ssc_in;
    seen_d = seen_q | link.limit_in | new_err | link.ssc_in;
    engaged_d = engaged_q;
    xfault_d = xfault_q;
    abort_d = abort_q;
    wstop_d = 1'b0;
    shared_service_request_set = 1'b0;
    case (state_q)
      S_IDLE: begin
        if (link.launch) begin
          if (stale_error_block) begin
            shared_service_request_set = 1'b1;
            if ((link.func == FN_READ) || (link.func == FN_WRITE)) begin
              abort_d = 1'b1;
            end
          end else if (link.func == FN_REWIND) begin
            shared_service_request_set = 1'b1;
          end else if (link.func != FN_NOP) begin
            state_d = S_RUN;
            func_d = link.func;
            cnt_d = 8'(OP_CYCLES);
            engaged_d = 1'b1;
            xfault_d = 1'b0;
            abort_d = 1'b0;
            seen_d = 1'b0;
          end
        end
      end
      S_RUN: begin
        cnt_d = cnt_q - 8'h01;
        if (is_xfer && new_err) begin
          xfault_d = 1'b1;
          // an error in the first cycle is one raised while starting
          if (abort_cause || (cnt_q == 8'(OP_CYCLES))) begin
            abort_d = 1'b1;
            if (is_write) begin
              wstop_d = 1'b1;
              state_d = S_GAP;
              cnt_d = 8'(GAP_CYCLES);
            end
          end
        end else if (cnt_q == 8'h01) begin
          state_d = S_DONE;
        end
      end
      S_GAP: begin
        cnt_d = cnt_q - 8'h01; // gap erased before motion stops
        if (cnt_q == 8'h01) begin
          state_d = S_DONE;
        end
      end
      default: begin
        state_d = S_IDLE;
        engaged_d = 1'b0;
        if ((func_q == FN_ERASE) || (func_q == FN_WR_MARK) || (func_q == FN_SPACE_FWD) ||
            (func_q == FN_SPACE_REV)) begin
          shared_service_request_set = 1'b1;
        end
        if (seen_q) begin
          shared_service_request_set = 1'b1;
        end
      end
    endcase
    // a clear in the same cycle as a new event loses to the event
    shared_service_request_flag_d = shared_service_request_flag_q;
    if (link.shared_service_request_wr && link.shared_service_request_wdata[UNIT]) begin
      shared_service_request_flag_d = 1'b0;
    end
    if (shared_service_request_set) begin
      shared_service_request_flag_d = 1'b1;
    end
    if (link.err_clear) begin
      ssc_d = link.ssc_in;
    end
    rdata_d = 8'h00;
    if (link.shared_service_request_rd) begin
      rdata_d[UNIT] = shared_service_request_flag_q;
    end
  end

  // -----------------------------------------------------------------
  // registers
  // -----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= S_IDLE;
      err_q <= 16'h0000;
      func_q <= FN_NOP;
      cnt_q <= 8'h00;
      shared_service_request_flag_q <= 1'b0;
      ssc_q <= 1'b0;
      seen_q <= 1'b0;
      engaged_q <= 1'b0;
      xfault_q <= 1'b0;
      abort_q <= 1'b0;
      wstop_q <= 1'b0;
      rdata_q <= 8'h00;
    end else begin
      state_q <= state_d;
      err_q <= err_d;
      func_q <= func_d;
      cnt_q <= cnt_d;
      shared_service_request_flag_q <= shared_service_request_flag_d;
      ssc_q <= ssc_d;
      seen_q <= seen_d;
      engaged_q <= engaged_d;
      xfault_q <= xfault_d;
      abort_q <= abort_d;
      wstop_q <= wstop_d;
      rdata_q <= rdata_d;
    end
  end

  assign link.err_q_out = err_q;
  assign link.fault_summary = any_error_summary;
  assign link.ssc_out = ssc_q;
  assign link.drive_engaged = engaged_q;
  assign link.shared_service_request = shared_service_request_flag_q;
  assign link.transfer_fault_line = xfault_q;
  assign link.end_of_block_abort = abort_q;
  assign link.write_stop = wstop_q;
  assign link.busy = state_q != S_IDLE;
  assign link.shared_service_request_rdata = rdata_q;
endmodule

/* verif/tape_link_properties.sv */
/* checker for the formatter link between the two ends.
   assumes one pclk domain; the bench instantiates it beside the interface. */
`timescale 1ns/1ns
module tape_link_properties
  import tape_exc_pkg::*;
#(
  parameter logic [2:0] UNIT = 3'h0
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic launch,
  input wire logic [4:0] func,
  input wire logic [15:0] tctrl,
  input wire logic err_inject,
  input wire logic [15:0] err_bits,
  input wire logic err_clear,
  input wire logic shared_service_request_rd,
  input wire logic shared_service_request_wr,
  input wire logic [7:0] shared_service_request_wdata,
  input wire logic [7:0] shared_service_request_rdata,
  input wire logic [15:0] err_q_out,
  input wire logic fault_summary,
  input wire logic drive_engaged,
  input wire logic shared_service_request,
  input wire logic transfer_fault_line,
  input wire logic end_of_block_abort,
  input wire logic write_stop,
  input wire logic busy
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic xfer;
  logic take;
  logic hit;
  assign xfer = (func == FN_READ) || (func == FN_WRITE);
  assign take = launch && !busy;
  // clear wins over injection in the error bits only; hit leaves cleared injections out
  assign hit = busy && xfer && err_inject && !err_clear;
  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  summary_match_a:
    assert property (fault_summary == (|err_q_out))
    else $error("fault summary differs from error bits");
  refused_engage_a:
    assert property (take && fault_summary |=> !drive_engaged && !busy)
    else $error("launch ran with error pending");
  refused_shared_service_request_a:
    assert property (take && fault_summary && func != FN_NOP |=> shared_service_request)
    else $error("refused launch gave no attention");
  pending_abort_a:
    assert property (take && fault_summary && xfer |=> end_of_block_abort)
    else $error("transfer with pending error not aborted");
  rewind_shared_service_request_a:
    assert property (take && func == FN_REWIND |=> shared_service_request)
    else $error("rewind start gave no attention");
  xfer_fault_a:
    assert property (hit && err_bits != 16'h0000 |=> transfer_fault_line)
    else $error("transfer error not flagged at once");
  class_b_abort_a:
    assert property (hit && (err_bits & CLASS_B_MASK) != 16'h0000 |=> end_of_block_abort)
    else $error("class b error did not abort");
  data_abort_gate_a:
    assert property (hit && $past(busy) && $past(busy, 2) && !tctrl[ABORT_ENABLE_BIT]
      && !end_of_block_abort && (err_bits & ~DATA_ERR_MASK) == 16'h0000
      |=> !end_of_block_abort)
    else $error("data error aborted while disabled");
  write_stop_gap_a:
    assert property (write_stop |-> func == FN_WRITE ##1 busy [*6] ##[1:8] !busy)
    else $error("write stop gap length wrong");
  shared_service_request_read_a:
    assert property (shared_service_request_rd |=> shared_service_request_rdata[UNIT] == $past(shared_service_request))
    else $error("summary line does not show flag");
  shared_service_request_clear_a:
    assert property (shared_service_request_wr && shared_service_request_wdata[UNIT] && !busy && !$past(busy) && !launch
      |=> !shared_service_request)
    else $error("one written did not clear flag");
  refused_c: cover property (take && fault_summary);
  stop_c: cover property (write_stop);
  clear_c: cover property (shared_service_request_wr && shared_service_request_wdata[UNIT] && shared_service_request);
endmodule

/* verif/tb_tape_formatter_error_attention.sv */
/* bench for both ends joined by the link, driven over apb.
   assumes an apb slave that may insert wait states and one formatter on unit 2. */
`timescale 1ns/1ns
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin failures++; \
  $display("ERROR %s expected %h seen %h", n, e, g); end end
module tb_tape_formatter_error_attention;
  import tape_exc_pkg::*;
  localparam logic [2:0] U = 3'h2;
  localparam logic [31:0] ATT = (32'h1 << ST_SERVICE) | (32'h1 << (ST_SHARED_SERVICE_REQUEST_SHIFT + U));
  localparam logic [4:0] MOV [4] = '{FN_ERASE, FN_WR_MARK, FN_SPACE_FWD, FN_SPACE_REV};
  localparam logic [4:0] FN [6] = '{FN_READ, FN_READ, FN_READ, FN_READ, FN_READ, FN_WRITE};
  localparam logic [31:0] TC [6] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h1000, 32'h0};
  localparam logic [31:0] EV [6] = '{32'h0, 32'h10000, 32'h20000, 32'h20, 32'h80, 32'h1000};
  localparam logic [31:0] MID [6] = '{32'h80, 32'h82, 32'h80, 32'h90, 32'hB0, 32'h30};
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [31:0] v;
  logic slverr_seen;
  int failures = 0;
  int checks_done = 0;
  int cyc = 0;
  tape_link_if link ();
  tape_formatter_exc #(.UNIT(U)) i_tape_formatter_exc (.pclk(pclk), .presetn(presetn),
    .link(link));
  tape_bus_controller i_tape_bus_controller (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .link(link));
  tape_link_properties #(.UNIT(U)) i_tape_link_properties (.pclk(pclk), .presetn(presetn),
    .launch(link.launch), .func(link.func), .tctrl(link.tctrl), .err_inject(link.err_inject),
    .err_bits(link.err_bits), .err_clear(link.err_clear), .shared_service_request_rd(link.shared_service_request_rd),
    .shared_service_request_wr(link.shared_service_request_wr), .shared_service_request_wdata(link.shared_service_request_wdata), .shared_service_request_rdata(link.shared_service_request_rdata),
    .err_q_out(link.err_q_out), .fault_summary(link.fault_summary),
    .drive_engaged(link.drive_engaged), .shared_service_request(link.shared_service_request),
    .transfer_fault_line(link.transfer_fault_line),
    .end_of_block_abort(link.end_of_block_abort), .write_stop(link.write_stop),
    .busy(link.busy));
  always #20 pclk = ~pclk;
  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic results;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // read data is taken at the edge that sees pready, before the slave updates
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    v = prdata;
    slverr_seen = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
    input string n);
    apb(1'b0, a, 32'h0);
    `CHK(n, e, v & m)
  endtask
  task automatic launch_fn(input logic [4:0] f);
    apb(1'b1, A_CMD, {26'h0, f, 1'b1});
  endtask
  task automatic wait_idle;
    for (int i = 0; i < 40; i++) begin
      apb(1'b0, A_STATUS, 32'h0);
      if (v[ST_BUSY] === 1'b0) break;
    end
  endtask
  task automatic clr;
    apb(1'b1, A_EVENT, 32'h40000);
    apb(1'b1, A_SHARED_SERVICE_REQUEST, 32'h1 << U);
  endtask
  always @(posedge pclk) begin
    cyc++;
    if (cyc > 6000) begin
      failures++;
      results();
    end
  end
  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    chk(A_STATUS, 32'hFFFF, 32'h0, "status reset");
    chk(A_ERROR, 32'hFFFF, 32'h0, "error reset");
    `CHK("mapped no error", 1'b0, slverr_seen)
    apb(1'b0, 8'h18, 32'h0);
    `CHK("unmapped error", 1'b1, slverr_seen)
    `CHK("unmapped data", 32'h0, v)
    $display("test reset done");
    apb(1'b1, A_EVENT, 32'h2);
    chk(A_ERROR, 32'hFFFF, 32'h2, "error bits");
    chk(A_STATUS, 32'h1, 32'h1, "fault bit");
    launch_fn(FN_READ);
    chk(A_STATUS, 32'h4AC, ATT | 32'h20, "refused read");
    chk(A_SHARED_SERVICE_REQUEST, 32'hFF, 32'h1 << U, "summary line");
    apb(1'b1, A_SHARED_SERVICE_REQUEST, ~(32'h1 << U) & 32'hFF);
    chk(A_SHARED_SERVICE_REQUEST, 32'hFF, 32'h1 << U, "zero keeps flag");
    apb(1'b1, A_SHARED_SERVICE_REQUEST, 32'h1 << U);
    chk(A_SHARED_SERVICE_REQUEST, 32'hFF, 32'h0, "one clears flag");
    clr();
    $display("test refused launch done");
    launch_fn(FN_REWIND);
    chk(A_STATUS, 32'h488, ATT, "rewind start");
    clr();
    for (int k = 0; k < 4; k++) begin
      launch_fn(MOV[k]);
      chk(A_STATUS, 32'h48C, 32'h84, "motion running");
      wait_idle();
      chk(A_STATUS, 32'h488, ATT, "motion end");
      clr();
    end
    $display("test motion done");
    // the write case leaves busy out: the gap may still be running
    for (int k = 0; k < 6; k++) begin
      apb(1'b1, A_TCTRL, TC[k]);
      launch_fn(FN[k]);
      repeat (3) @(posedge pclk);
      apb(1'b1, A_EVENT, EV[k]);
      chk(A_STATUS, k < 5 ? 32'hB2 : 32'h32, MID[k], "mid op");
      wait_idle();
      chk(A_STATUS, 32'h488, k > 0 ? ATT : 32'h0, "op end");
      clr();
    end
    $display("test transfer done");
    results();
  end
endmodule
